// ### fcp_coproc_end.sv
`timescale 1ns/100ps
module fcp_coproc_end
  import fcp_pkg::*;
#(
  parameter int COPROC_ID = 1,
  parameter logic [7:0] UNORD_VECTOR = FCP_UNORD_VEC_DEF
)
(
  input wire logic clock,
  input wire logic nrst,
  fcp_link_if.coproc link,
  input wire logic cc_n,
  input wire logic cc_z,
  input wire logic cc_nan,
  input wire logic unord_trap_en,
  input wire logic unord_clear,
  input wire logic op_done,
  output logic branch_unordered_flag,
  output logic op_start,
  output logic op_busy,
  output logic op_ext_source,
  output logic [2:0] source_float_reg,
  output logic [2:0] op_src_fmt,
  output logic state_suspend,
  output logic state_load,
  output logic [FCP_STATE_W-1:0] internal_state
);
  initial
  begin
    if (COPROC_ID < 0 || COPROC_ID > 7)
      $error("COPROC_ID must be 0 to 7");
  end

  localparam logic [2:0] MY_ID = 3'(COPROC_ID);

  logic [2:0] op_type;
  logic [2:0] ea_mode;
  logic [2:0] ea_reg;
  logic [FCP_PRED_W-1:0] pred;
  logic rm_bit;
  logic [2:0] src_spec;
  logic id_hit;
  fcp_ea_cat_t ea_cat;

  logic next_valid;
  fcp_prim_t next_prim;
  logic next_true;
  logic [7:0] next_vector;
  logic next_set_unord;
  logic next_start;
  logic next_suspend;
  logic next_load;

  assign op_type = link.req_opword[FCP_TYPE_LSB+2:FCP_TYPE_LSB];
  assign ea_mode = link.req_opword[FCP_MODE_LSB+2:FCP_MODE_LSB];
  assign ea_reg = link.req_opword[FCP_REG_LSB+2:FCP_REG_LSB];
  // Upper predicate bit 5 and the rest of the word are don't-care
  assign pred = link.req_cmdword[FCP_PRED_W-1:0];
  assign rm_bit = link.req_cmdword[FCP_RM_BIT];
  assign src_spec = link.req_cmdword[FCP_SRC_LSB+2:FCP_SRC_LSB];
  // Other IDs are left to their own coprocessor; no answer at all
  assign id_hit = link.req_valid && (link.req_opword[FCP_ID_LSB+2:FCP_ID_LSB] == MY_ID);

  fcp_ea_class u_ea
  (
    .mode(ea_mode),
    .regno(ea_reg),
    .cat(ea_cat)
  );

  always_comb
  begin
    next_valid = id_hit;
    next_prim = FCP_PRIM_NULL;
    next_true = 1'b0;
    next_vector = 8'h00;
    next_set_unord = 1'b0;
    next_start = 1'b0;
    next_suspend = 1'b0;
    next_load = 1'b0;
    if (id_hit)
    begin
      case (op_type)
        FCP_TYPE_COND, FCP_TYPE_BRW, FCP_TYPE_BRL:
        begin
          // Both branch sizes and all conditional forms look alike here
          next_true = fcp_eval_pred(pred[3:0], cc_n, cc_z, cc_nan);
          if (pred[FCP_SIG_BIT] && cc_nan)
          begin
            next_set_unord = 1'b1;
            if (unord_trap_en)
            begin
              next_prim = FCP_PRIM_PRE_EXC;
              next_vector = UNORD_VECTOR;
            end
          end
          else
            next_prim = FCP_PRIM_NULL;
        end
        FCP_TYPE_SAVE:
          if ((ea_cat.ctrl && ea_cat.alt) || ea_mode == FCP_EA_PREDEC)
          begin
            next_prim = FCP_PRIM_STATE;
            next_suspend = 1'b1;
          end
          else
            next_prim = FCP_PRIM_FLINE;
        FCP_TYPE_REST:
          if (ea_cat.ctrl || ea_mode == FCP_EA_POSTINC)
          begin
            next_prim = FCP_PRIM_NULL;
            next_load = 1'b1;
          end
          else
            next_prim = FCP_PRIM_FLINE;
        FCP_TYPE_GEN:
          // External source needs a valid mode and a listed format
          if (rm_bit && (src_spec == FCP_FMT_NONE || !ea_cat.valid))
            next_prim = FCP_PRIM_FLINE;
          else
            next_start = 1'b1;
        default: next_prim = FCP_PRIM_FLINE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      link.resp_valid <= 1'b0;
      link.resp_prim <= FCP_PRIM_NULL;
      link.resp_come_again <= 1'b0;
      link.resp_true <= 1'b0;
      link.resp_vector <= 8'h00;
      link.resp_state <= FCP_STATE_RST;
    end
    else
    begin
      link.resp_valid <= next_valid;
      link.resp_prim <= next_prim;
      link.resp_come_again <= 1'b0;
      link.resp_true <= next_true;
      link.resp_vector <= next_vector;
      // Save shows the state as it stood before this cycle's update
      link.resp_state <= next_suspend ? internal_state : FCP_STATE_RST;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      branch_unordered_flag <= 1'b0;
    else if (next_set_unord)
      branch_unordered_flag <= 1'b1;
    else if (unord_clear)
      branch_unordered_flag <= 1'b0;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      internal_state <= FCP_STATE_RST;
    else if (next_load)
      internal_state <= link.req_state;
  end

  // Save and restore abort whatever runs; a done never outranks them
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      op_busy <= 1'b0;
    else if (next_suspend || next_load)
      op_busy <= 1'b0;
    else if (next_start)
      op_busy <= 1'b1;
    else if (op_done)
      op_busy <= 1'b0;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      op_start <= 1'b0;
      state_suspend <= 1'b0;
      state_load <= 1'b0;
    end
    else
    begin
      op_start <= next_start;
      state_suspend <= next_suspend;
      state_load <= next_load;
    end
  end

  // Source fields held from the last accepted general operation
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      op_ext_source <= 1'b0;
      source_float_reg <= 3'h0;
      op_src_fmt <= FCP_FMT_NONE;
    end
    else if (next_start)
    begin
      op_ext_source <= rm_bit;
      source_float_reg <= rm_bit ? 3'h0 : src_spec;
      op_src_fmt <= rm_bit ? src_spec : FCP_FMT_NONE;
    end
  end
endmodule // fcp_coproc_end

// ### fcp_cpu_end.sv
`timescale 1ns/100ps
module fcp_cpu_end
  import fcp_pkg::*;
#(
  parameter int TIMEOUT_CYC = FCP_TIMEOUT_DEF
)
(
  input wire logic clock,
  input wire logic nrst,
  fcp_link_if.cpu link,
  input wire logic start,
  input wire logic [FCP_WORD_W-1:0] opword,
  input wire logic [FCP_WORD_W-1:0] cmdword,
  input wire logic [FCP_STATE_W-1:0] state_in,
  input wire logic [1:0] cond_form,
  input wire logic [FCP_ADDR_W-1:0] disp_addr,
  input wire logic [31:0] disp,
  input wire logic disp_long,
  input wire logic [15:0] counter_in,
  output logic busy,
  output logic done,
  output logic fault_fline,
  output logic fault_pre_exc,
  output logic no_response,
  output logic [7:0] exc_vector,
  output logic cond_true,
  output logic take_branch,
  output logic trap_taken,
  output logic [FCP_ADDR_W-1:0] branch_target,
  output logic [15:0] counter_out,
  output logic [FCP_STATE_W-1:0] state_out
);
  initial
  begin
    if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 65535)
      $error("TIMEOUT_CYC must be 1 to 65535");
  end

  localparam logic [15:0] TIMEOUT_LAST = 16'(TIMEOUT_CYC - 1);

  typedef enum logic {FCP_HST_IDLE, FCP_HST_WAIT} fcp_host_state_t;
  fcp_host_state_t state;
  logic [15:0] timer;
  logic [1:0] form_q;
  logic is_cond_q;
  logic [FCP_ADDR_W-1:0] target_q;
  logic [15:0] count_q;
  logic legal;
  logic is_cond;
  logic [2:0] op_type;
  fcp_ea_cat_t ea_cat;
  logic [15:0] count_dec;

  assign op_type = opword[FCP_TYPE_LSB+2:FCP_TYPE_LSB];
  assign is_cond = op_type == FCP_TYPE_COND || op_type == FCP_TYPE_BRW || op_type == FCP_TYPE_BRL;
  assign count_dec = count_q - 16'h0001;

  fcp_ea_class u_ea
  (
    .mode(opword[FCP_MODE_LSB+2:FCP_MODE_LSB]),
    .regno(opword[FCP_REG_LSB+2:FCP_REG_LSB]),
    .cat(ea_cat)
  );

  always_comb
  begin
    legal = 1'b1;
    if (op_type == FCP_TYPE_SAVE)
      legal = (ea_cat.ctrl && ea_cat.alt) || opword[5:3] == FCP_EA_PREDEC;
    else if (op_type == FCP_TYPE_REST)
      legal = ea_cat.ctrl || opword[5:3] == FCP_EA_POSTINC;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= FCP_HST_IDLE;
      timer <= 16'h0000;
      form_q <= FCP_FORM_BRANCH;
      is_cond_q <= 1'b0;
      target_q <= '0;
      count_q <= 16'h0000;
      link.req_valid <= 1'b0;
      link.req_opword <= 16'h0000;
      link.req_cmdword <= 16'h0000;
      link.req_state <= FCP_STATE_RST;
    end
    else
    begin
      link.req_valid <= 1'b0;
      case (state)
        FCP_HST_IDLE:
          if (start && legal)
          begin
            state <= FCP_HST_WAIT;
            timer <= 16'h0000;
            form_q <= op_type == FCP_TYPE_COND ? cond_form : FCP_FORM_BRANCH;
            is_cond_q <= is_cond;
            // Offset counts from the displacement word; short form sign-extended
            target_q <= disp_addr + (disp_long ? disp : {{16{disp[15]}}, disp[15:0]});
            count_q <= counter_in;
            link.req_valid <= 1'b1;
            link.req_opword <= opword;
            // Branch predicates sit in the opword; pass them as a predicate word
            link.req_cmdword <= op_type == FCP_TYPE_BRW || op_type == FCP_TYPE_BRL
                                ? {10'h000, opword[FCP_PRED_W-1:0]} : cmdword;
            link.req_state <= state_in;
          end
        FCP_HST_WAIT:
          if (link.resp_valid || timer == TIMEOUT_LAST)
            state <= FCP_HST_IDLE;
          else
            timer <= timer + 16'h0001;
        default: state <= FCP_HST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      fault_fline <= 1'b0;
      fault_pre_exc <= 1'b0;
      no_response <= 1'b0;
      exc_vector <= 8'h00;
      cond_true <= 1'b0;
      take_branch <= 1'b0;
      trap_taken <= 1'b0;
      branch_target <= '0;
      counter_out <= 16'h0000;
      state_out <= FCP_STATE_RST;
    end
    else
    begin
      done <= 1'b0;
      if (state == FCP_HST_IDLE && start)
      begin
        busy <= legal;
        done <= !legal;
        fault_fline <= !legal;
        fault_pre_exc <= 1'b0;
        no_response <= 1'b0;
        take_branch <= 1'b0;
        trap_taken <= 1'b0;
      end
      else if (state == FCP_HST_WAIT && link.resp_valid)
      begin
        busy <= 1'b0;
        done <= 1'b1;
        fault_fline <= link.resp_prim == FCP_PRIM_FLINE;
        fault_pre_exc <= link.resp_prim == FCP_PRIM_PRE_EXC;
        exc_vector <= link.resp_vector;
        cond_true <= link.resp_true;
        state_out <= link.resp_state;
        branch_target <= target_q;
        if (is_cond_q && link.resp_prim == FCP_PRIM_NULL)
          case (form_q)
            FCP_FORM_BRANCH: take_branch <= link.resp_true;
            FCP_FORM_DECBR:
              if (!link.resp_true)
              begin
                counter_out <= count_dec;
                take_branch <= count_dec != FCP_COUNT_END;
              end
            // Operand words are skipped here, never sent across
            FCP_FORM_TRAP: trap_taken <= link.resp_true;
            default: take_branch <= 1'b0;
          endcase
      end
      else if (state == FCP_HST_WAIT && timer == TIMEOUT_LAST)
      begin
        busy <= 1'b0;
        done <= 1'b1;
        no_response <= 1'b1;
      end
    end
  end
endmodule // fcp_cpu_end

// ### fcp_ea_class.sv
`timescale 1ns/100ps
module fcp_ea_class
  import fcp_pkg::*;
(
  input wire logic [2:0] mode,
  input wire logic [2:0] regno,
  output fcp_ea_cat_t cat
);
  always_comb
  begin
    cat = '0;
    case (mode)
      FCP_EA_DREG: cat = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
      FCP_EA_AREG: cat = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
      FCP_EA_IND, FCP_EA_DISP, FCP_EA_INDEX: cat = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
      FCP_EA_POSTINC, FCP_EA_PREDEC: cat = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
      FCP_EA_EXT:
        case (regno)
          FCP_EXT_ABS_W, FCP_EXT_ABS_L: cat = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
          FCP_EXT_PC_DISP, FCP_EXT_PC_INDEX: cat = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
          FCP_EXT_IMM: cat = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
          default: cat = '0;
        endcase
      default: cat = '0;
    endcase
  end
endmodule // fcp_ea_class

// ### fcp_link_asserts.sv
`timescale 1ns/100ps
module fcp_link_asserts
  import fcp_pkg::*;
#(
  parameter int COPROC_ID = 1,
  parameter logic [7:0] UNORD_VECTOR = FCP_UNORD_VEC_DEF
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic [FCP_WORD_W-1:0] req_opword,
  input wire logic [FCP_WORD_W-1:0] req_cmdword,
  input wire logic [FCP_STATE_W-1:0] req_state,
  input wire logic resp_valid,
  input wire fcp_prim_t resp_prim,
  input wire logic resp_come_again,
  input wire logic resp_true,
  input wire logic [7:0] resp_vector,
  input wire logic [FCP_STATE_W-1:0] resp_state
);
  logic hit;
  logic is_cond;
  logic rst_ok;
  logic [2:0] rtype;
  logic [2:0] rmode;
  logic [FCP_STATE_W-1:0] saved_state;
  assign hit = req_valid && (req_opword[11:9] == COPROC_ID[2:0]);
  assign rtype = req_opword[8:6];
  assign rmode = req_opword[5:3];
  assign is_cond = rtype == FCP_TYPE_COND || rtype == FCP_TYPE_BRW || rtype == FCP_TYPE_BRL;
  assign rst_ok = rmode == FCP_EA_POSTINC || rmode == FCP_EA_IND || rmode == FCP_EA_DISP
    || rmode == FCP_EA_INDEX || (rmode == FCP_EA_EXT && req_opword[2:0] <= 3'h3);

  // Shadow of the state a save must hand back
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      saved_state <= FCP_STATE_RST;
    else if (hit && rtype == FCP_TYPE_REST && rst_ok)
      saved_state <= req_state;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  property p_answer;
    hit |=> resp_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer to own id");
  property p_foreign;
    req_valid && !hit |=> !resp_valid;
  endproperty
  a_foreign: assert property (p_foreign) else $error("answer to foreign id");
  property p_ca;
    resp_valid |-> !resp_come_again;
  endproperty
  a_ca: assert property (p_ca) else $error("come-again set");
  property p_nonsig;
    hit && is_cond && !req_cmdword[FCP_SIG_BIT] |=> resp_prim == FCP_PRIM_NULL;
  endproperty
  a_nonsig: assert property (p_nonsig)
    else $error("non-signaling not null");
  property p_vector;
    resp_valid && resp_prim == FCP_PRIM_PRE_EXC |-> resp_vector == UNORD_VECTOR;
  endproperty
  a_vector: assert property (p_vector) else $error("wrong exception vector");
  property p_save_state;
    resp_valid && resp_prim == FCP_PRIM_STATE |-> resp_state == saved_state;
  endproperty
  a_save_state: assert property (p_save_state) else $error("saved state wrong");
  property p_save_legal;
    hit && rtype == FCP_TYPE_SAVE && rmode == FCP_EA_PREDEC |=> resp_prim == FCP_PRIM_STATE;
  endproperty
  a_save_legal: assert property (p_save_legal) else $error("save refused");
  property p_restore;
    hit && rtype == FCP_TYPE_REST && rst_ok |=> resp_valid && resp_prim == FCP_PRIM_NULL;
  endproperty
  a_restore: assert property (p_restore) else $error("restore refused");
  property p_gen_reg;
    hit && rtype == FCP_TYPE_GEN && !req_cmdword[FCP_RM_BIT] |=> resp_prim == FCP_PRIM_NULL;
  endproperty
  a_gen_reg: assert property (p_gen_reg)
    else $error("register op refused");
  property p_gen_fmt;
    hit && rtype == FCP_TYPE_GEN && req_cmdword[14] && req_cmdword[12:10] == 3'h7
      |=> resp_prim == FCP_PRIM_FLINE;
  endproperty
  a_gen_fmt: assert property (p_gen_fmt) else $error("bad format accepted");

  c_save: cover property (hit && rtype == FCP_TYPE_SAVE);
  c_restore: cover property (hit && rtype == FCP_TYPE_REST);
  c_pre_exc: cover property (resp_valid && resp_prim == FCP_PRIM_PRE_EXC);
  c_foreign: cover property (req_valid && !hit);
endmodule // fcp_link_asserts

// ### fcp_link_if.sv
`timescale 1ns/100ps
interface fcp_link_if;
  import fcp_pkg::*;
  logic req_valid;
  logic [FCP_WORD_W-1:0] req_opword;
  logic [FCP_WORD_W-1:0] req_cmdword;
  logic [FCP_STATE_W-1:0] req_state;
  logic resp_valid;
  fcp_prim_t resp_prim;
  logic resp_come_again;
  logic resp_true;
  logic [7:0] resp_vector;
  logic [FCP_STATE_W-1:0] resp_state;

  modport coproc (input req_valid, req_opword, req_cmdword, req_state,
                  output resp_valid, resp_prim, resp_come_again, resp_true, resp_vector,
                  resp_state);
  modport cpu (output req_valid, req_opword, req_cmdword, req_state,
               input resp_valid, resp_prim, resp_come_again, resp_true, resp_vector,
               resp_state);
endinterface

// ### fcp_pkg.sv
package fcp_pkg;
  localparam int FCP_WORD_W = 16;
  localparam int FCP_STATE_W = 32;
  localparam int FCP_ADDR_W = 32;
  localparam int FCP_ID_LSB = 9;
  localparam int FCP_TYPE_LSB = 6;
  localparam int FCP_MODE_LSB = 3;
  localparam int FCP_REG_LSB = 0;
  localparam int FCP_RM_BIT = 14;
  localparam int FCP_SRC_LSB = 10;
  localparam int FCP_PRED_W = 6;
  localparam int FCP_SIG_BIT = 4;
  localparam logic [2:0] FCP_TYPE_GEN = 3'h0;
  localparam logic [2:0] FCP_TYPE_COND = 3'h1;
  localparam logic [2:0] FCP_TYPE_BRW = 3'h2;
  localparam logic [2:0] FCP_TYPE_BRL = 3'h3;
  localparam logic [2:0] FCP_TYPE_SAVE = 3'h4;
  localparam logic [2:0] FCP_TYPE_REST = 3'h5;
  localparam logic [2:0] FCP_EA_DREG = 3'h0;
  localparam logic [2:0] FCP_EA_AREG = 3'h1;
  localparam logic [2:0] FCP_EA_IND = 3'h2;
  localparam logic [2:0] FCP_EA_POSTINC = 3'h3;
  localparam logic [2:0] FCP_EA_PREDEC = 3'h4;
  localparam logic [2:0] FCP_EA_DISP = 3'h5;
  localparam logic [2:0] FCP_EA_INDEX = 3'h6;
  localparam logic [2:0] FCP_EA_EXT = 3'h7;
  localparam logic [2:0] FCP_EXT_ABS_W = 3'h0;
  localparam logic [2:0] FCP_EXT_ABS_L = 3'h1;
  localparam logic [2:0] FCP_EXT_PC_DISP = 3'h2;
  localparam logic [2:0] FCP_EXT_PC_INDEX = 3'h3;
  localparam logic [2:0] FCP_EXT_IMM = 3'h4;
  localparam logic [2:0] FCP_FMT_LONG = 3'h0;
  localparam logic [2:0] FCP_FMT_SINGLE = 3'h1;
  localparam logic [2:0] FCP_FMT_EXT = 3'h2;
  localparam logic [2:0] FCP_FMT_PACKED = 3'h3;
  localparam logic [2:0] FCP_FMT_WORD = 3'h4;
  localparam logic [2:0] FCP_FMT_DOUBLE = 3'h5;
  localparam logic [2:0] FCP_FMT_BYTE = 3'h6;
  localparam logic [2:0] FCP_FMT_NONE = 3'h7;
  localparam logic [1:0] FCP_FORM_BRANCH = 2'h0;
  localparam logic [1:0] FCP_FORM_SET = 2'h1;
  localparam logic [1:0] FCP_FORM_DECBR = 2'h2;
  localparam logic [1:0] FCP_FORM_TRAP = 2'h3;
  localparam logic [FCP_STATE_W-1:0] FCP_STATE_RST = 32'h0000_0000;
  localparam logic [15:0] FCP_COUNT_END = 16'hffff;
  localparam int FCP_TIMEOUT_DEF = 16;
  // Vector value is arbitrary
  localparam logic [7:0] FCP_UNORD_VEC_DEF = 8'h10;

  typedef enum logic [1:0] {FCP_PRIM_NULL, FCP_PRIM_PRE_EXC, FCP_PRIM_FLINE, FCP_PRIM_STATE}
    fcp_prim_t;

  typedef struct packed {
    logic valid;
    logic data;
    logic mem;
    logic ctrl;
    logic alt;
  } fcp_ea_cat_t;

  // Low four predicate bits against N, Z and not-a-number
  function automatic logic fcp_eval_pred(input logic [3:0] p, input logic n,
                                         input logic z, input logic not_a_number_code);
    logic r;
    r = 1'b0;
    case (p)
      4'h0: r = 1'b0;
      4'h1: r = z;
      4'h2: r = ~(not_a_number_code | z | n);
      4'h3: r = z | ~(not_a_number_code | n);
      4'h4: r = n & ~(not_a_number_code | z);
      4'h5: r = z | (n & ~not_a_number_code);
      4'h6: r = ~(not_a_number_code | z);
      4'h7: r = ~not_a_number_code;
      4'h8: r = not_a_number_code;
      4'h9: r = not_a_number_code | z;
      4'ha: r = not_a_number_code | ~(n | z);
      4'hb: r = not_a_number_code | z | ~n;
      4'hc: r = not_a_number_code | (n & ~z);
      4'hd: r = not_a_number_code | z | n;
      4'he: r = ~z;
      default: r = 1'b1;
    endcase
    return r;
  endfunction
endpackage

// ### test_fpu_cond_predicate_and_field_decode.sv
`timescale 1ns/100ps
module test_fpu_cond_predicate_and_field_decode;
  import fcp_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic start = 1'b0;
  logic [15:0] opword = 16'h0000;
  logic [15:0] cmdword = 16'h0000;
  logic [31:0] state_in = 32'h0000_0000;
  logic [31:0] disp_addr = 32'h0000_0000;
  logic [31:0] disp = 32'h0000_0000;
  logic [15:0] counter_in = 16'h0000;
  logic [1:0] cond_form = 2'h0;
  logic disp_long = 1'b0;
  logic cc_n = 1'b0, cc_z = 1'b0, cc_nan = 1'b0, unord_trap_en = 1'b0;
  logic unord_clear = 1'b0, op_done = 1'b0;
  logic busy, done, fault_fline, fault_pre_exc, no_response, cond_true, take_branch;
  logic trap_taken, flag, op_start, op_busy, op_ext_source, state_suspend, state_load;
  logic [7:0] exc_vector;
  logic [31:0] branch_target, state_out, internal_state, exp_state, r;
  logic [15:0] counter_out;
  logic [2:0] source_float_reg, op_src_fmt;
  logic [5:0] pr;
  logic res, exc, ok;
  int bad_count = 0;
  int checks_done = 0;
  int seed = 32'hf5eaed1b;
  int n_start = 0, n_susp = 0, n_load = 0, e_start = 0, e_susp = 0, e_load = 0;

  fcp_link_if link();
  fcp_cpu_end #(.TIMEOUT_CYC(4)) u_fcp_cpu_end (.clock(clock), .nrst(nrst), .link(link),
    .start(start), .opword(opword), .cmdword(cmdword), .state_in(state_in),
    .cond_form(cond_form), .disp_addr(disp_addr), .disp(disp), .disp_long(disp_long),
    .counter_in(counter_in), .busy(busy), .done(done), .fault_fline(fault_fline),
    .fault_pre_exc(fault_pre_exc), .no_response(no_response), .exc_vector(exc_vector),
    .cond_true(cond_true), .take_branch(take_branch), .trap_taken(trap_taken),
    .branch_target(branch_target), .counter_out(counter_out), .state_out(state_out));
  fcp_coproc_end #(.COPROC_ID(1), .UNORD_VECTOR(FCP_UNORD_VEC_DEF)) u_fcp_coproc_end (
    .clock(clock), .nrst(nrst), .link(link), .cc_n(cc_n), .cc_z(cc_z), .cc_nan(cc_nan),
    .unord_trap_en(unord_trap_en), .unord_clear(unord_clear), .op_done(op_done),
    .branch_unordered_flag(flag), .op_start(op_start), .op_busy(op_busy),
    .op_ext_source(op_ext_source), .source_float_reg(source_float_reg),
    .op_src_fmt(op_src_fmt), .state_suspend(state_suspend), .state_load(state_load),
    .internal_state(internal_state));
  fcp_link_asserts #(.COPROC_ID(1), .UNORD_VECTOR(FCP_UNORD_VEC_DEF)) u_fcp_link_asserts (
    .clock(clock), .nrst(nrst), .req_valid(link.req_valid), .req_opword(link.req_opword),
    .req_cmdword(link.req_cmdword), .req_state(link.req_state),
    .resp_valid(link.resp_valid), .resp_prim(link.resp_prim),
    .resp_come_again(link.resp_come_again), .resp_true(link.resp_true),
    .resp_vector(link.resp_vector), .resp_state(link.resp_state));

  always #10 clock = ~clock;

  // Pulses counted at the edge that ends them
  always @(posedge clock)
  begin
    n_start += (op_start === 1'b1);
    n_susp += (state_suspend === 1'b1);
    n_load += (state_load === 1'b1);
  end

  // Bit order of the low nibble is unordered, less, greater, equal
  function automatic logic pexp(input logic [3:0] p, input logic n, input logic z,
                                input logic u);
    return |(p & {u, n & ~(u | z), ~(u | z | n), z});
  endfunction

  function automatic logic ea_ok(input logic sv, input logic [2:0] m, input logic [2:0] g);
    logic ctl;
    logic alt;
    ctl = m == 3'h2 || m == 3'h5 || m == 3'h6 || (m == 3'h7 && g <= 3'h3);
    alt = m != 3'h7 || g <= 3'h1;
    return sv ? ((ctl & alt) | (m == 3'h4)) : (ctl | (m == 3'h3));
  endfunction

  task automatic check(input logic good, input string msg);
    checks_done++;
    if (good !== 1'b1)
    begin
      bad_count++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Condition codes never show not-a-number and zero together
  task automatic do_op(input logic [15:0] ow, input logic [15:0] cw, input logic [1:0] form);
    logic [31:0] rr;
    int n;
    n = 0;
    rr = $random(seed);
    @(posedge clock);
    opword <= ow;
    cmdword <= cw;
    cond_form <= form;
    start <= 1'b1;
    unord_clear <= 1'b1;
    cc_n <= rr[0];
    cc_z <= rr[1] & ~rr[2];
    cc_nan <= rr[2];
    unord_trap_en <= rr[3];
    disp_long <= rr[4] & (form == FCP_FORM_BRANCH);
    counter_in <= (rr[15:13] == 3'h0) ? 16'h0000 : rr[31:16];
    state_in <= $random(seed);
    disp <= $random(seed);
    disp_addr <= $random(seed);
    @(posedge clock);
    start <= 1'b0;
    unord_clear <= 1'b0;
    #1;
    check(busy === !done, "busy");
    while (done !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    check(n < 20, "no done");
  endtask

  initial
  begin
    #(20 * 5000);
    bad_count++;
    $display("MISMATCH at %0t: watchdog", $time);
    stop_test();
  end

  initial
  begin
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 64; i++)
    begin
      r = $random(seed);
      pr = i[5:0];
      if (r[7:6] == FCP_FORM_BRANCH)
        do_op({4'hf, 3'h1, (r[8] ? FCP_TYPE_BRL : FCP_TYPE_BRW), pr}, 16'h0000, r[7:6]);
      else
        do_op({4'hf, 3'h1, FCP_TYPE_COND, 6'h00}, {r[31:22], pr}, r[7:6]);
      res = pexp(pr[3:0], cc_n, cc_z, cc_nan);
      exc = pr[4] & cc_nan & unord_trap_en;
      check(fault_pre_exc === exc, "exception");
      check(exc_vector === (exc ? FCP_UNORD_VEC_DEF : 8'h00), "vector");
      check(fault_fline === 1'b0, "reserved bits trapped");
      check(flag === (pr[4] & cc_nan), "unordered flag");
      if (!exc)
        check(cond_true === res, "predicate");
      check(take_branch === (!exc && (r[7:6] == FCP_FORM_BRANCH ? res : r[7:6] == FCP_FORM_DECBR
        && !res && 16'(counter_in - 16'h1) != FCP_COUNT_END)), "branch");
      check(trap_taken === (r[7:6] == FCP_FORM_TRAP && !exc && res), "trap");
      if (r[7:6] == FCP_FORM_DECBR && !exc && !res)
        check(counter_out === counter_in - 16'h1, "counter");
      if (r[7:6] == FCP_FORM_BRANCH || r[7:6] == FCP_FORM_DECBR)
        check(branch_target === disp_addr + (disp_long ? disp : {{16{disp[15]}}, disp[15:0]}),
          "target");
    end
    $display("predicate test done");
    for (int k = 0; k < 16; k++)
    begin
      do_op({4'hf, 3'h1, FCP_TYPE_GEN, 6'h10}, {1'b0, k[3], 1'b0, k[2:0], 10'h000}, 2'h0);
      ok = !(k[3] && k[2:0] == 3'h7);
      check(fault_fline === !ok, "format refusal");
      if (ok)
      begin
        e_start++;
        check(op_ext_source === k[3], "source select");
        check(source_float_reg === (k[3] ? 3'h0 : k[2:0]), "source reg");
        check(op_src_fmt === (k[3] ? k[2:0] : 3'h7), "format");
        check(op_busy === 1'b1, "busy");
      end
    end
    @(posedge clock);
    op_done <= 1'b1;
    @(posedge clock);
    op_done <= 1'b0;
    #1;
    check(op_busy === 1'b0, "op end");
    do_op({4'hf, 3'h1, FCP_TYPE_GEN, 6'h10}, 16'h0000, 2'h0);
    e_start++;
    check(n_start === e_start, "start pulses");
    exp_state = FCP_STATE_RST;
    do_op({4'hf, 3'h1, FCP_TYPE_SAVE, 6'h20}, 16'h0000, 2'h0);
    e_susp++;
    check(op_busy === 1'b0, "save suspend");
    check(state_out === exp_state, "save reset state");
    $display("field test done");
    for (int k = 0; k < 128; k++)
    begin
      do_op({4'hf, 3'h1, (k[0] ? FCP_TYPE_REST : FCP_TYPE_SAVE), k[6:1]}, 16'h0000, 2'h0);
      ok = ea_ok(!k[0], k[6:4], k[3:1]);
      check(fault_fline === !ok, "mode check");
      e_load += ok & k[0];
      e_susp += ok & !k[0];
      if (ok && k[0])
        exp_state = state_in;
      if (ok && !k[0])
        check(state_out === exp_state, "save state");
      check(internal_state === exp_state, "restore state");
    end
    check(n_susp === e_susp && n_load === e_load, "state pulses");
    $display("save restore test done");
    for (int k = 0; k < 8; k++)
    begin
      do_op({4'hf, k[2:0], FCP_TYPE_COND, 6'h00}, 16'h000f, 2'h1);
      check(no_response === (k != 1), "id select");
    end
    do_op({4'hf, 3'h1, 3'h6, 6'h00}, 16'h0000, 2'h0);
    check(fault_fline === 1'b1, "unknown type");
    $display("id test done");
    stop_test();
  end
endmodule // test_fpu_cond_predicate_and_field_decode
